// [rtl/acdci_pkg.sv]
// Shared constants and carrier types of the audio codec DMA count and interrupt block.
// Assumes a 100 MHz system clock and a single AHB-Lite master with word accesses.
package acdci_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CODEC_STATE = 8'h00;
   localparam logic [7:0] OFS_ALT_FEATURE = 8'h04;
   localparam logic [7:0] OFS_PIN_CTRL = 8'h08;
   localparam logic [7:0] OFS_EXTRA_CTRL = 8'h0C;
   localparam logic [7:0] OFS_ALT_FLAG = 8'h10;
   localparam logic [7:0] OFS_ECHO_CTRL = 8'h14;
   localparam logic [7:0] OFS_ECHO_RIGHT = 8'h18;
   localparam logic [7:0] OFS_PLAY_BASE_LO = 8'h1C;
   localparam logic [7:0] OFS_PLAY_BASE_HI = 8'h20;
   localparam logic [7:0] OFS_REC_BASE_LO = 8'h24;
   localparam logic [7:0] OFS_REC_BASE_HI = 8'h28;
   localparam logic [7:0] OFS_TIMER_LO = 8'h2C;
   localparam logic [7:0] OFS_TIMER_HI = 8'h30;
   localparam logic [7:0] OFS_DMA_COUNTS = 8'h34;
   localparam logic [7:0] OFS_TIMER_COUNT = 8'h38;

   // Field positions
   localparam int ECHO_ON_BIT = 4;
   localparam int SPLIT_GAIN_BIT = 4;
   localparam int IRQ_MASK_BIT = 0;
   localparam int ACCUM_CLEAR_BIT = 0;

   // Formats and FIFO sizes
   localparam logic [1:0] FMT_PCM8 = 2'h0;
   localparam logic [1:0] FMT_PCM16 = 2'h1;
   localparam logic [1:0] FMT_ADPCM = 2'h2;
   localparam logic [6:0] ADPCM_FIFO_BYTES = 7'h40;
   localparam logic [6:0] PCM_FIFO_BYTES = 7'h40;

   // Timer tick: about 10 us at 100 MHz
   localparam int CLK_PERIOD_NS = 10;
   localparam int TIMER_TICK_NS = 10000;
   localparam logic [9:0] TICK_CYCLES = 10'(TIMER_TICK_NS / CLK_PERIOD_NS);

   // Reset values
   localparam logic [15:0] CTRL_RESET = 16'h0040;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

   typedef struct packed {
      logic underrun_hold_select;
      logic rec_compress_hold;
      logic rec_stereo;
      logic play_stereo;
      logic [1:0] rec_fmt;
      logic [1:0] play_fmt;
      logic [1:0] mode;
      logic countdown_run_bit;
      logic format_unlock;
      logic rec_programmed_io;
      logic play_programmed_io;
      logic rec_run;
      logic play_run;
   } acdci_ctrl_t;

   typedef struct packed {
      logic rec_overrun_flag;
      logic play_starved_flag;
      logic countdown_wrapped_flag;
      logic capture_wrap_flag;
      logic playback_wrap_flag;
   } acdci_flags_t;

   typedef struct packed {
      logic signed [15:0] l;
      logic signed [15:0] r;
   } acdci_stereo_t;

   typedef struct packed {
      logic [15:0] accum;
      logic [6:0] step;
   } acdci_adpcm_t;

endpackage

// [rtl/acdci_top.sv]
// DMA sample counters, countdown timer, interrupt, ADPCM state control and digital loopback.
// Assumes FIFOs, converters and the ADPCM arithmetic sit outside; their strobes are synchronous.
`timescale 1ns/1ps
`default_nettype none

module acdci_top import acdci_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Playback stream
   input wire logic play_byte_ack,
   input wire logic play_fifo_full,
   input wire logic play_fifo_empty,
   input wire logic play_sample_tick,
   input wire acdci_stereo_t play_data,
   output logic play_drq,
   output logic play_fifo_rd,
   output logic [6:0] play_fifo_limit,
   // Capture stream
   input wire logic rec_byte_ack,
   input wire logic rec_fifo_full,
   input wire logic rec_fifo_empty,
   input wire logic rec_sample_tick,
   input wire logic rec_comp_byte,
   output logic rec_drq,
   output logic rec_fifo_wr,
   output logic rec_comp_en,
   output logic [6:0] rec_fifo_limit,
   // ADPCM state exchange
   input wire logic play_adpcm_upd,
   input wire acdci_adpcm_t play_adpcm_new,
   input wire logic rec_adpcm_upd,
   input wire acdci_adpcm_t rec_adpcm_new,
   output acdci_adpcm_t play_adpcm,
   output acdci_adpcm_t rec_adpcm,
   // Mixer
   input wire acdci_stereo_t adc_data,
   output acdci_stereo_t dac_data,
   // Interrupt pin
   output logic irq
);

   typedef struct packed {
      logic dph_wr;
      logic dph_rd;
      logic rd_wait;
      logic [7:0] dph_addr;
      logic [31:0] rdata;
      acdci_ctrl_t ctrl;
      logic irq_mask_bit;
      logic play_accum_clear;
      acdci_flags_t flags;
      logic echo_path_on;
      logic [3:0] gain_l;
      logic split_echo_gain;
      logic [3:0] gain_r;
      logic [15:0] play_base;
      logic [15:0] rec_base;
      logic [15:0] timer_base;
      logic [15:0] play_cur;
      logic [15:0] rec_cur;
      logic [15:0] timer_cur;
      logic [9:0] presc;
      logic te_prev;
      logic [1:0] play_bcnt;
      logic [1:0] rec_bcnt;
      logic [1:0] rec_wbcnt;
      acdci_stereo_t play_last;
      acdci_adpcm_t play_st;
      acdci_adpcm_t rec_st;
      acdci_stereo_t dac;
   } acdci_state_t;

   acdci_state_t st;
   acdci_state_t n;

   // Derived stream conditions
   logic play_dma_ok;
   logic rec_dma_ok;
   logic mode1;
   logic [2:0] play_bps;
   logic [2:0] rec_bps;
   logic [2:0] play_grp;
   logic [2:0] rec_grp;
   logic [2:0] play_b1;
   logic [2:0] rec_b1;
   logic play_evt;
   logic rec_evt;
   logic rec_frozen;
   logic play_freeze;
   logic timer_tick;
   logic codec_irq_pending;
   logic wr_ok;
   acdci_stereo_t echo;
   logic signed [16:0] sum_l;
   logic signed [16:0] sum_r;

   // Bytes per counted sample
   function automatic logic [2:0] bytes_per(input logic [1:0] fmt);
      unique case (fmt)
         FMT_PCM16: bytes_per = 3'h2;
         FMT_ADPCM: bytes_per = 3'h4;
         default: bytes_per = 3'h1;
      endcase
   endfunction

   // Request burst length: four bytes for ADPCM and 16-bit stereo
   function automatic logic [2:0] group_of(input logic [1:0] fmt, input logic stereo);
      if (fmt == FMT_ADPCM || (fmt == FMT_PCM16 && stereo)) begin
         group_of = 3'h4;
      end else begin
         group_of = bytes_per(fmt);
      end
   endfunction

   // Saturate a 17-bit sum to 16 bits instead of wrapping
   function automatic logic signed [15:0] sat16(input logic signed [16:0] s);
      if (s[16] != s[15]) begin
         sat16 = s[16] ? 16'sh8000 : 16'sh7FFF;
      end else begin
         sat16 = s[15:0];
      end
   endfunction

   assign mode1 = (st.ctrl.mode < 2'h2);
   assign play_dma_ok = st.ctrl.play_run && !st.ctrl.play_programmed_io;
   // One base pair in mode 1: capture DMA yields while playback DMA owns it
   assign rec_dma_ok = st.ctrl.rec_run && !st.ctrl.rec_programmed_io
      && !(mode1 && play_dma_ok);
   assign play_bps = bytes_per(st.ctrl.play_fmt);
   assign rec_bps = bytes_per(st.ctrl.rec_fmt);
   assign play_grp = group_of(st.ctrl.play_fmt, st.ctrl.play_stereo);
   assign rec_grp = group_of(st.ctrl.rec_fmt, st.ctrl.rec_stereo);
   assign play_b1 = {1'b0, st.play_bcnt} + 3'h1;
   assign rec_b1 = {1'b0, st.rec_bcnt} + 3'h1;
   assign play_evt = play_byte_ack && play_dma_ok && ((play_b1 & (play_bps - 3'h1)) == 3'h0);
   assign rec_evt = rec_byte_ack && rec_dma_ok && ((rec_b1 & (rec_bps - 3'h1)) == 3'h0);
   assign rec_frozen = st.ctrl.rec_compress_hold && (st.rec_wbcnt == 2'h0);
   assign play_freeze = play_fifo_empty;
   assign timer_tick = st.ctrl.countdown_run_bit && st.te_prev && (st.presc == TICK_CYCLES - 10'h1);
   assign codec_irq_pending = st.flags.playback_wrap_flag || st.flags.capture_wrap_flag
      || st.flags.countdown_wrapped_flag;
   assign wr_ok = st.dph_wr;

   // Loopback: common gain unless split, mono capture feeds both sides
   assign echo.l = st.echo_path_on ? (adc_data.l >>> st.gain_l) : 16'sh0000;
   assign echo.r = st.echo_path_on ? ((st.ctrl.rec_stereo ? adc_data.r : adc_data.l)
      >>> (st.split_echo_gain ? st.gain_r : st.gain_l)) : 16'sh0000;
   assign sum_l = {st.play_last.l[15], st.play_last.l} + {echo.l[15], echo.l};
   assign sum_r = {st.play_last.r[15], st.play_last.r} + {echo.r[15], echo.r};

   // Handshakes and outputs; a started group keeps its request up to the end
   assign play_drq = play_dma_ok && (st.play_bcnt != 2'h0 || !play_fifo_full);
   assign rec_drq = rec_dma_ok && (st.rec_bcnt != 2'h0 || !rec_fifo_empty);
   assign play_fifo_rd = play_sample_tick && st.ctrl.play_run && !play_fifo_empty;
   // A full FIFO drops the new sample so the one under transfer survives
   assign rec_fifo_wr = rec_sample_tick && st.ctrl.rec_run && !rec_fifo_full;
   assign rec_comp_en = st.ctrl.rec_run && !rec_frozen;
   assign play_fifo_limit = (st.ctrl.play_fmt == FMT_ADPCM) ? ADPCM_FIFO_BYTES
      : PCM_FIFO_BYTES;
   assign rec_fifo_limit = (st.ctrl.rec_fmt == FMT_ADPCM) ? ADPCM_FIFO_BYTES
      : PCM_FIFO_BYTES;
   assign irq = codec_irq_pending && st.irq_mask_bit;
   assign hreadyout = !(st.dph_rd && !st.rd_wait);
   assign hresp = 1'b0;
   assign hrdata = st.rdata;
   assign play_adpcm = st.play_st;
   assign rec_adpcm = st.rec_st;
   assign dac_data = st.dac;

   // Next-state logic
   always_comb begin
      acdci_flags_t fset;
      acdci_flags_t wz;
      logic p_wrap;
      logic r_wrap;
      logic rp_wrap;
      n = st;
      fset = '0;
      wz = '1;
      p_wrap = 1'b0;
      r_wrap = 1'b0;
      rp_wrap = 1'b0;

      // Bus address phase; reads wait one cycle so the data comes from a flop
      n.dph_wr = hsel && hready && htrans[1] && hwrite;
      n.dph_rd = (st.dph_rd && !st.rd_wait) || (hsel && hready && htrans[1] && !hwrite);
      n.rd_wait = st.dph_rd && !st.rd_wait;
      if (hsel && hready && htrans[1]) begin
         n.dph_addr = haddr[7:0];
      end
      if (st.dph_rd && !st.rd_wait) begin
         unique case (st.dph_addr)
            OFS_CODEC_STATE: n.rdata = {27'h0, st.rec_bcnt, st.play_bcnt, codec_irq_pending};
            OFS_ALT_FEATURE: n.rdata = {16'h0, st.ctrl};
            OFS_PIN_CTRL: n.rdata = {31'h0, st.irq_mask_bit};
            OFS_EXTRA_CTRL: n.rdata = {31'h0, st.play_accum_clear};
            OFS_ALT_FLAG: n.rdata = {27'h0, st.flags};
            OFS_ECHO_CTRL: n.rdata = {27'h0, st.echo_path_on, st.gain_l};
            OFS_ECHO_RIGHT: n.rdata = {27'h0, st.split_echo_gain, st.gain_r};
            OFS_PLAY_BASE_LO: n.rdata = {24'h0, st.play_base[7:0]};
            OFS_PLAY_BASE_HI: n.rdata = {24'h0, st.play_base[15:8]};
            OFS_REC_BASE_LO: n.rdata = {24'h0, st.rec_base[7:0]};
            OFS_REC_BASE_HI: n.rdata = {24'h0, st.rec_base[15:8]};
            OFS_TIMER_LO: n.rdata = {24'h0, st.timer_base[7:0]};
            OFS_TIMER_HI: n.rdata = {24'h0, st.timer_base[15:8]};
            OFS_DMA_COUNTS: n.rdata = {st.rec_cur, st.play_cur};
            OFS_TIMER_COUNT: n.rdata = {16'h0, st.timer_cur};
            default: n.rdata = RDATA_UNMAPPED;
         endcase
      end

      // Byte position inside a request group, also the PIO byte index
      if (play_byte_ack) begin
         n.play_bcnt = (play_b1 >= play_grp) ? 2'h0 : play_b1[1:0];
      end
      if (rec_byte_ack) begin
         n.rec_bcnt = (rec_b1 >= rec_grp) ? 2'h0 : rec_b1[1:0];
      end

      // Sample counters: decrement to zero, the next sample wraps and reloads
      if (play_evt) begin
         p_wrap = (st.play_cur == 16'h0000);
         n.play_cur = p_wrap ? st.play_base : st.play_cur - 16'h0001;
      end
      if (rec_evt && mode1) begin
         rp_wrap = (st.play_cur == 16'h0000);
         n.play_cur = rp_wrap ? st.play_base : st.play_cur - 16'h0001;
      end else if (rec_evt) begin
         r_wrap = (st.rec_cur == 16'h0000);
         n.rec_cur = r_wrap ? st.rec_base : st.rec_cur - 16'h0001;
      end
      fset.playback_wrap_flag = p_wrap || rp_wrap;
      fset.capture_wrap_flag = r_wrap;

      // Countdown timer: load on enable, tick every 10 us, flag at zero
      n.te_prev = st.ctrl.countdown_run_bit;
      if (!st.ctrl.countdown_run_bit || !st.te_prev) begin
         n.presc = 10'h000;
         if (st.ctrl.countdown_run_bit) begin
            n.timer_cur = st.timer_base;
         end
      end else begin
         n.presc = timer_tick ? 10'h000 : st.presc + 10'h001;
      end
      if (timer_tick) begin
         if (st.timer_cur == 16'h0000) begin
            n.timer_cur = st.timer_base;
         end else begin
            n.timer_cur = st.timer_cur - 16'h0001;
            fset.countdown_wrapped_flag = (st.timer_cur == 16'h0001);
         end
      end

      // Playback sample clock: repeat the last sample or zero on underrun
      if (play_sample_tick && st.ctrl.play_run) begin
         if (!play_fifo_empty) begin
            n.play_last = play_data;
         end else begin
            fset.play_starved_flag = 1'b1;
            if (st.ctrl.underrun_hold_select) begin
               n.play_last = '0;
            end
         end
      end
      fset.rec_overrun_flag = rec_sample_tick && st.ctrl.rec_run && rec_fifo_full;
      n.dac.l = sat16(sum_l);
      n.dac.r = sat16(sum_r);

      // Compressed bytes delivered toward the capture FIFO, counted per word
      if (!st.ctrl.rec_run) begin
         n.rec_wbcnt = 2'h0;
      end else if (rec_comp_byte) begin
         n.rec_wbcnt = st.rec_wbcnt + 2'h1;
      end

      // ADPCM state: cleared while stopped, frozen on hold or underrun
      if (!st.ctrl.rec_run) begin
         n.rec_st = '0;
      end else if (rec_adpcm_upd && !rec_frozen) begin
         n.rec_st = rec_adpcm_new;
      end
      if (!st.ctrl.play_run) begin
         n.play_st = '0;
      end else begin
         if (play_adpcm_upd && !play_freeze) begin
            n.play_st = play_adpcm_new;
         end
         if (st.play_accum_clear) begin
            n.play_st.accum = 16'h0000;
         end
      end

      // Register writes in the data phase
      if (wr_ok) begin
         unique case (st.dph_addr)
            OFS_CODEC_STATE: begin
               wz.playback_wrap_flag = 1'b0;
               wz.capture_wrap_flag = 1'b0;
               wz.countdown_wrapped_flag = 1'b0;
            end
            OFS_ALT_FEATURE: begin
               n.ctrl = acdci_ctrl_t'(hwdata[15:0]);
               // Transfer mode bits stay put unless the format is unlocked
               if (!st.ctrl.format_unlock) begin
                  n.ctrl.play_programmed_io = st.ctrl.play_programmed_io;
                  n.ctrl.rec_programmed_io = st.ctrl.rec_programmed_io;
               end
            end
            OFS_PIN_CTRL: n.irq_mask_bit = hwdata[IRQ_MASK_BIT];
            OFS_EXTRA_CTRL: n.play_accum_clear = hwdata[ACCUM_CLEAR_BIT];
            OFS_ALT_FLAG: begin
               wz = acdci_flags_t'(hwdata[4:0]) | ~st.flags;
               // Error flags ignore the clear while the cause is still there
               wz.play_starved_flag = hwdata[3] || play_fifo_empty;
               wz.rec_overrun_flag = hwdata[4] || rec_fifo_full;
            end
            OFS_ECHO_CTRL: begin
               n.echo_path_on = hwdata[ECHO_ON_BIT];
               n.gain_l = hwdata[3:0];
            end
            OFS_ECHO_RIGHT: begin
               n.split_echo_gain = hwdata[SPLIT_GAIN_BIT];
               n.gain_r = hwdata[3:0];
            end
            OFS_PLAY_BASE_LO: n.play_base[7:0] = hwdata[7:0];
            OFS_PLAY_BASE_HI: begin
               n.play_base[15:8] = hwdata[7:0];
               n.play_cur = {hwdata[7:0], st.play_base[7:0]};
            end
            OFS_REC_BASE_LO: n.rec_base[7:0] = hwdata[7:0];
            OFS_REC_BASE_HI: begin
               n.rec_base[15:8] = hwdata[7:0];
               n.rec_cur = {hwdata[7:0], st.rec_base[7:0]};
            end
            OFS_TIMER_LO: n.timer_base[7:0] = hwdata[7:0];
            OFS_TIMER_HI: n.timer_base[15:8] = hwdata[7:0];
            default: ;
         endcase
      end
      // A new event wins over a clear in the same cycle
      n.flags = (st.flags & wz) | fset;
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.ctrl <= acdci_ctrl_t'(CTRL_RESET);
         st.play_cur <= COUNT_RESET;
         st.rec_cur <= COUNT_RESET;
      end else begin
         st <= n;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // While masked, a roll-under still raises the pending bit but never the pin
   property p_irq_masked;
      !st.irq_mask_bit && play_evt && st.play_cur == 16'h0000 && !wr_ok
         |=> codec_irq_pending && !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq high while masked");

   property p_rec_clear;
      !st.ctrl.rec_run |=> rec_adpcm == '0;
   endproperty
   a_rec_clear: assert property (p_rec_clear) else $error("capture state not cleared");

   property p_play_clear;
      !st.ctrl.play_run |=> play_adpcm == '0;
   endproperty
   a_play_clear: assert property (p_play_clear) else $error("playback state not cleared");

   property p_accum_clear;
      st.ctrl.play_run && st.play_accum_clear && !play_adpcm_upd
         |=> play_adpcm.accum == 16'h0000 && play_adpcm.step == $past(play_adpcm.step);
   endproperty
   a_accum_clear: assert property (p_accum_clear) else $error("accum clear misbehaved");

   property p_base_load;
      wr_ok && st.dph_addr == OFS_PLAY_BASE_HI
         |=> st.play_cur == {$past(hwdata[7:0]), $past(st.play_base[7:0])};
   endproperty
   a_base_load: assert property (p_base_load) else $error("current count not loaded");

   property p_count_down;
      play_evt && st.play_cur != 16'h0000 && !wr_ok && !(rec_evt && mode1)
         |=> st.play_cur == $past(st.play_cur) - 16'h0001;
   endproperty
   a_count_down: assert property (p_count_down) else $error("count did not decrement");

   property p_wrap_flag;
      play_evt && st.play_cur == 16'h0000 |=> st.flags.playback_wrap_flag && codec_irq_pending;
   endproperty
   a_wrap_flag: assert property (p_wrap_flag) else $error("wrap flag not set");

   property p_drq_gate;
      (play_drq |-> st.ctrl.play_run && !st.ctrl.play_programmed_io)
         and (rec_drq |-> st.ctrl.rec_run && !st.ctrl.rec_programmed_io);
   endproperty
   a_drq_gate: assert property (p_drq_gate) else $error("request outside DMA mode");

   property p_timer_flag;
      timer_tick && st.timer_cur == 16'h0001 |=> st.flags.countdown_wrapped_flag;
   endproperty
   a_timer_flag: assert property (p_timer_flag) else $error("timer flag not set");

   property p_starved_hold;
      st.flags.play_starved_flag && play_fifo_empty |=> st.flags.play_starved_flag;
   endproperty
   a_starved_hold: assert property (p_starved_hold) else $error("starved flag lost");

   property p_saturate;
      sum_l > 17'sh07FFF |=> dac_data.l == 16'sh7FFF;
   endproperty
   a_saturate: assert property (p_saturate) else $error("mixer wrapped");

   c_play_wrap: cover property (play_evt && st.play_cur == 16'h0000);
   c_timer_wrap: cover property (timer_tick && st.timer_cur == 16'h0001);
   c_underrun: cover property (play_sample_tick && st.ctrl.play_run && play_fifo_empty);
   c_overrun: cover property (rec_sample_tick && st.ctrl.rec_run && rec_fifo_full);

endmodule // acdci_top

`default_nettype wire

// [sim/acdci_host_model.sv]
// Behavioural ISA host DMA side: answers the playback request with byte acknowledges.
// Assumes one clock; the bench sets how many bytes to move and the stall between them.
`timescale 1ns/1ps
`default_nettype none
module acdci_host_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Request side
   input wire logic drq,
   input wire logic [7:0] want,
   input wire logic [1:0] gap,
   // Acknowledge side
   output logic ack,
   output logic [7:0] sent
);
   logic [1:0] wait_cnt;

   // Every requested byte is delivered, none dropped; gap gives a slow host
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack <= 1'b0;
         sent <= 8'h00;
         wait_cnt <= 2'h0;
      end else begin
         ack <= 1'b0;
         if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
         end else if (drq && sent < want && !ack) begin
            ack <= 1'b1;
            sent <= sent + 8'h01;
            wait_cnt <= gap;
         end
      end
   end
endmodule // acdci_host_model
`default_nettype wire

// [sim/audio_codec_dma_count_irq_tb.sv]
// Testbench: registers over AHB-Lite, playback DMA counting, wrap flag and interrupt pin.
// Assumes the host model moves playback bytes; capture inputs idle.
`timescale 1ns/1ps
`default_nettype none
module audio_codec_dma_count_irq_tb;
   import acdci_pkg::*;
   logic clk_sys, rst, hsel, hwrite, hreadyout, hresp, irq, pack, play_drq;
   logic [1:0] htrans, gap;
   logic [2:0] hsize;
   logic [7:0] want, sent;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic pfull, pempty, ptick, rfull, rempty, rtick, rbyte, rack, pupd, rupd;
   acdci_stereo_t pdata, adc, dac;
   acdci_adpcm_t pnew, rnew, padpcm, radpcm;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;

   acdci_top acdci_top_i (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .play_byte_ack(pack),
      .play_fifo_full(pfull), .play_fifo_empty(pempty), .play_sample_tick(ptick),
      .play_data(pdata), .play_drq(play_drq), .play_fifo_rd(), .play_fifo_limit(),
      .rec_byte_ack(rack), .rec_fifo_full(rfull), .rec_fifo_empty(rempty),
      .rec_sample_tick(rtick), .rec_comp_byte(rbyte), .rec_drq(), .rec_fifo_wr(),
      .rec_comp_en(), .rec_fifo_limit(), .play_adpcm_upd(pupd), .play_adpcm_new(pnew),
      .rec_adpcm_upd(rupd), .rec_adpcm_new(rnew), .play_adpcm(padpcm), .rec_adpcm(radpcm),
      .adc_data(adc), .dac_data(dac), .irq(irq));

   acdci_host_model acdci_host_model_i (.clk_sys(clk_sys), .rst(rst), .drq(play_drq),
      .want(want), .gap(gap), .ack(pack), .sent(sent));

   // Clock of 10 ns and a hang guard well above the expected run
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One single transfer; address held until hready, data held until hready again
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic end_sim();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      {hsel, hwrite, htrans, hsize, haddr, hwdata, want, gap} = '0;
      {pfull, pempty, ptick, rfull, rempty, rtick, rbyte, rack, pupd, rupd} = '0;
      {pdata, adc, pnew, rnew} = '0;
      hsize = 3'h2;
      rst = 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      ahb(1'b0, OFS_ALT_FEATURE, 32'h0);
      chk(q, 32'h00000040);
      ahb(1'b0, 8'h7C, 32'h0);
      chk(q, RDATA_UNMAPPED);
      ahb(1'b1, OFS_ALT_FEATURE, 32'h00000084);
      ahb(1'b0, OFS_ALT_FEATURE, 32'h0);
      chk(q, 32'h00000080);
      // Playback state stays cleared while the stream is stopped
      pupd <= 1'b1;
      pnew <= 23'h12345;
      repeat (2) @(posedge clk_sys);
      chk(32'(padpcm), 32'h0);
      ahb(1'b1, OFS_PLAY_BASE_LO, 32'h02);
      ahb(1'b1, OFS_PLAY_BASE_HI, 32'h00);
      ahb(1'b0, OFS_DMA_COUNTS, 32'h0);
      chk(q & 32'hFFFF, 32'h2);
      ahb(1'b1, OFS_ALT_FEATURE, 32'h00000081);
      @(posedge clk_sys);
      pupd <= 1'b0;
      @(posedge clk_sys);
      chk(32'(padpcm), 32'h12345);
      // Accumulator clear keeps the step size
      ahb(1'b1, OFS_EXTRA_CTRL, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk(32'(padpcm), 32'h45);
      gap <= 2'h2;
      want <= 8'h02;
      wait (sent == 8'h02);
      ahb(1'b0, OFS_DMA_COUNTS, 32'h0);
      chk(q & 32'hFFFF, 32'h0);
      ahb(1'b0, OFS_ALT_FLAG, 32'h0);
      chk(q & 32'h1, 32'h0);
      want <= 8'h03;
      wait (sent == 8'h03);
      ahb(1'b0, OFS_DMA_COUNTS, 32'h0);
      chk(q & 32'hFFFF, 32'h2);
      ahb(1'b0, OFS_CODEC_STATE, 32'h0);
      chk(q & 32'h1, 32'h1);
      chk(32'(irq), 32'h0);
      ahb(1'b1, OFS_PIN_CTRL, 32'h1);
      @(posedge clk_sys);
      chk(32'(irq), 32'h1);
      ahb(1'b1, OFS_CODEC_STATE, 32'h0);
      ahb(1'b0, OFS_ALT_FLAG, 32'h0);
      chk(q & 32'h1, 32'h0);
      chk(32'(irq), 32'h0);
      // ADPCM counts four-byte words: a base of one wraps every eight bytes
      ahb(1'b1, OFS_ALT_FEATURE, 32'h00000281);
      ahb(1'b1, OFS_PLAY_BASE_LO, 32'h01);
      ahb(1'b1, OFS_PLAY_BASE_HI, 32'h00);
      want <= 8'h07;
      wait (sent == 8'h07);
      ahb(1'b0, OFS_DMA_COUNTS, 32'h0);
      chk(q & 32'hFFFF, 32'h0);
      want <= 8'h0B;
      wait (sent == 8'h0B);
      ahb(1'b0, OFS_ALT_FLAG, 32'h0);
      chk(q & 32'h1, 32'h1);
      chk(32'(irq), 32'h1);
      // Loopback: left clips, mono capture feeds the right side as well
      ahb(1'b1, OFS_ECHO_CTRL, 32'h10);
      pdata <= {16'h7000, 16'h1000};
      adc <= {16'h2000, 16'h0100};
      ptick <= 1'b1;
      @(posedge clk_sys);
      ptick <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({16'h0, dac.l}, 32'h7FFF);
      chk({16'h0, dac.r}, 32'h3000);
      // Underrun: last sample repeats, starved flag survives a clear while empty
      pempty <= 1'b1;
      ptick <= 1'b1;
      @(posedge clk_sys);
      ptick <= 1'b0;
      ahb(1'b1, OFS_ALT_FLAG, 32'h0);
      ahb(1'b0, OFS_ALT_FLAG, 32'h0);
      chk(q & 32'h8, 32'h8);
      chk({16'h0, dac.r}, 32'h3000);
      end_sim();
   end
endmodule // audio_codec_dma_count_irq_tb
`default_nettype wire
